// File: mcdma_regs.svh
// constants of the multichannel dma channel control block
`ifndef MCDMA_REGS_SVH
`define MCDMA_REGS_SVH

// ----------------------------------------------------------------------------
// channel counts
// ----------------------------------------------------------------------------
`define MCDMA_NUM_CH        32
`define MCDMA_NUM_STRUCT    64
`define MCDMA_SW_CH         5'h1e

// ----------------------------------------------------------------------------
// attribute bit positions
// ----------------------------------------------------------------------------
`define MCDMA_ATTR_BURST    0
`define MCDMA_ATTR_ALT      1
`define MCDMA_ATTR_HIPRI    2
`define MCDMA_ATTR_REQMASK  3

// ----------------------------------------------------------------------------
// reset values and fifo depth
// ----------------------------------------------------------------------------
`define MCDMA_EN_RST        32'h0000_0000
`define MCDMA_ATTR_RST      32'h0000_0000
`define MCDMA_REM_RST       11'h000
`define MCDMA_FIFO_DEPTH    4

`endif

// File: mcdma_pkg.sv
// types of the multichannel dma channel control block
`default_nettype none
package mcdma_pkg;

  typedef enum logic [2:0] {
    MCDMA_HALTED         = 3'b000,
    MCDMA_BASIC          = 3'b001,
    MCDMA_AUTO           = 3'b010,
    MCDMA_DOUBLE_BUFFER  = 3'b011,
    MCDMA_MEM_SG         = 3'b100,
    MCDMA_PERIPHERAL_SG  = 3'b101
  } mcdma_mode_t;

  typedef enum logic [1:0] {
    MCDMA_SIZE_8  = 2'b00,
    MCDMA_SIZE_16 = 2'b01,
    MCDMA_SIZE_32 = 2'b10
  } mcdma_size_t;

  typedef enum logic [1:0] {
    MCDMA_INC_BYTE  = 2'b00,
    MCDMA_INC_HALF  = 2'b01,
    MCDMA_INC_WORD  = 2'b10,
    MCDMA_INC_FIXED = 2'b11
  } mcdma_inc_t;

  typedef struct packed {
    mcdma_size_t size;
    mcdma_inc_t  src_inc;
    mcdma_inc_t  dst_inc;
    logic [3:0]  arb_exp;
    logic        tail_burst_only_flag;
    mcdma_mode_t mode;
    logic [9:0]  count_m1;
  } mcdma_ctrl_t;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    mcdma_size_t size;
    logic [4:0]  ch;
  } mcdma_xfer_t;

endpackage
`default_nettype wire

// File: mcdma_ctrl.sv
// channel control engine of the multichannel dma with its item fifo
`timescale 1ns/10ps
`default_nettype none
`include "mcdma_regs.svh"

// ----------------------------------------------------------------------------
// item fifo
// ----------------------------------------------------------------------------
module mcdma_fifo #(
  parameter int WIDTH = 71,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire              empty = (wr_q == rd_q);
  wire              push  = in_valid_in && !full;
  wire              pop   = out_ready_in && !empty;

  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule // mcdma_fifo

// How it works
// - a channel moves nothing until software has set its enable bit
// - on completion the engine clears the channel enable by itself, except when it swaps to the other structure
// - requests on a disabled channel, hardware or software, are ignored
// - completion writes the halted mode into the active structure
// - mode field holds halted, basic, auto, double buffer, memory and peripheral sg
// - item size field selects 8, 16 or 32 bit items
// - source address steps by byte, half-word, word or stays fixed
// - destination address steps by byte, half-word, word or stays fixed
// - after two to the arbitration exponent items the engine rearbitrates
// - with the tail flag set only burst and software requests are served
// - burst-only attribute makes the channel ignore single requests
// - alternate attribute chooses alternate or primary structure as active
// - high-priority attribute places the channel in the upper class
// - request-mask attribute blocks the peripheral hardware request
// - software may raise a request on any channel like a peripheral
// - software channel completes on own done line, others on peripheral line
// - each channel has a selectable peripheral assignment for its requests
// - each channel owns primary and alternate structures, written separately
// - all four attribute bits of a channel read back together
// - each channel enable state is readable for completion polling
// - sg channel runs as peripheral or memory sg as its mode selects
// - 32 channels; index bit five addresses the alternate structure
// - transfer count covers 1 to 1024 items
// - auto runs to completion; double buffer swaps primary and alternate
// - remaining count falls per item and reads zero when complete
module mcdma_ctrl (
  // clock and reset
  input  wire logic                  CLK_IN,
  input  wire logic                  RESETN_IN,
  // channel enables
  input  wire logic [31:0]           EN_SET_IN,
  input  wire logic [31:0]           EN_CLR_IN,
  output logic      [31:0]           ENABLE_OUT,
  // attributes
  input  wire logic                  ATTR_WR_IN,
  input  wire logic [4:0]            ATTR_CH_IN,
  input  wire logic [3:0]            ATTR_SET_IN,
  input  wire logic [3:0]            ATTR_CLR_IN,
  input  wire logic [4:0]            RD_CH_IN,
  output logic      [3:0]            ATTR_OUT,
  // control structures
  input  wire logic                  CFG_WR_IN,
  input  wire logic [5:0]            CFG_IDX_IN,
  input  wire mcdma_pkg::mcdma_ctrl_t CFG_CTRL_IN,
  input  wire logic [31:0]           CFG_SRC_IN,
  input  wire logic [31:0]           CFG_DST_IN,
  input  wire logic [5:0]            RD_IDX_IN,
  output mcdma_pkg::mcdma_mode_t     RD_MODE_OUT,
  output logic      [10:0]           RD_REMAIN_OUT,
  // peripheral assignment
  input  wire logic                  MAP_WR_IN,
  input  wire logic [4:0]            MAP_CH_IN,
  input  wire logic [4:0]            MAP_SEL_IN,
  // requests
  input  wire logic [31:0]           SW_REQ_IN,
  input  wire logic [31:0]           PERIPH_SREQ_IN,
  input  wire logic [31:0]           PERIPH_BREQ_IN,
  // completion
  output logic                       DONE_SW_OUT,
  output logic      [31:0]           PERIPH_DONE_OUT,
  // item stream to the bus master
  output mcdma_pkg::mcdma_xfer_t     BUS_XFER_OUT,
  output logic                       BUS_VALID_OUT,
  input  wire logic                  BUS_READY_IN,
  output logic                       BUSY_OUT
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MOVE  = 2'b01,
    ST_CLOSE = 2'b10
  } mcdma_state_t;

  mcdma_state_t           state_q;
  logic [31:0]            en_q;
  logic [31:0]            burst_q;
  logic [31:0]            alt_q;
  logic [31:0]            hipri_q;
  logic [31:0]            mask_q;
  logic [31:0]            sw_pend_q;
  logic [31:0]            started_q;
  logic [4:0]             map_q [32];
  mcdma_pkg::mcdma_ctrl_t ctrl_mem [64];
  logic [10:0]            rem_mem [64];
  logic [31:0]            src_mem [64];
  logic [31:0]            dst_mem [64];
  logic [4:0]             act_ch_q;
  logic [10:0]            beat_q;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] step_of(input mcdma_pkg::mcdma_inc_t inc);
    case (inc)
      mcdma_pkg::MCDMA_INC_BYTE: step_of = 32'h0000_0001;
      mcdma_pkg::MCDMA_INC_HALF: step_of = 32'h0000_0002;
      mcdma_pkg::MCDMA_INC_WORD: step_of = 32'h0000_0004;
      default:                   step_of = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [4:0] first_set(input logic [31:0] v);
    first_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // request qualification
  // --------------------------------------------------------------------------
  logic [31:0] hw_req;
  logic [31:0] want;
  always_comb begin
    for (int i = 0; i < `MCDMA_NUM_CH; i++) begin
      // mask hw request, burst only, tail flag
      hw_req[i] = !mask_q[i] && (PERIPH_BREQ_IN[map_q[i]] || (PERIPH_SREQ_IN[map_q[i]]
                  && !burst_q[i] && !ctrl_mem[{alt_q[i], 5'(i)}].tail_burst_only_flag));
      want[i]   = en_q[i] && ctrl_mem[{alt_q[i], 5'(i)}].mode != mcdma_pkg::MCDMA_HALTED
                  && (hw_req[i] || sw_pend_q[i] || started_q[i]);
    end
  end

  wire  [31:0] want_hi  = want & hipri_q;
  wire  [4:0]  pick_ch  = (|want_hi) ? first_set(want_hi) : first_set(want);
  wire         go       = (state_q == ST_IDLE) && (|want);

  wire  [5:0]  act_idx  = {alt_q[act_ch_q], act_ch_q};
  wire  [5:0]  pick_idx = {alt_q[pick_ch], pick_ch};
  wire  [5:0]  oth_idx  = {!alt_q[act_ch_q], act_ch_q};
  mcdma_pkg::mcdma_ctrl_t act_ctl;
  assign act_ctl = ctrl_mem[act_idx];

  // --------------------------------------------------------------------------
  // item move
  // --------------------------------------------------------------------------
  logic                  fifo_ready;
  mcdma_pkg::mcdma_xfer_t item;
  wire         move_ok  = (state_q == ST_MOVE) && en_q[act_ch_q];
  wire         push     = move_ok && fifo_ready;
  wire  [10:0] rem_now  = rem_mem[act_idx];
  wire         last     = (rem_now == 11'h001);
  wire  [10:0] arb_cnt  = 11'h001 << act_ctl.arb_exp;
  wire         chunk    = (beat_q + 11'h001) == arb_cnt;
  wire         basic_gone = (act_ctl.mode == mcdma_pkg::MCDMA_BASIC) && !hw_req[act_ch_q]
                            && !started_q[act_ch_q];
  // double buffer and sg continue on the other structure
  wire         swap     = ((act_ctl.mode == mcdma_pkg::MCDMA_DOUBLE_BUFFER)
                          || (act_ctl.mode == mcdma_pkg::MCDMA_MEM_SG)
                          || (act_ctl.mode == mcdma_pkg::MCDMA_PERIPHERAL_SG))
                          && (ctrl_mem[oth_idx].mode != mcdma_pkg::MCDMA_HALTED);
  wire         finish   = (state_q == ST_CLOSE) && !swap;

  assign item.src  = src_mem[act_idx];
  assign item.dst  = dst_mem[act_idx];
  assign item.size = act_ctl.size;
  assign item.ch   = act_ch_q;

  mcdma_fifo #(
    .WIDTH ($bits(mcdma_pkg::mcdma_xfer_t)),
    .DEPTH (`MCDMA_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLK_IN),
    .resetn_in     (RESETN_IN),
    .in_valid_in   (move_ok),
    .in_ready_out  (fifo_ready),
    .in_data_in    (item),
    .out_valid_out (BUS_VALID_OUT),
    .out_ready_in  (BUS_READY_IN),
    .out_data_out  (BUS_XFER_OUT)
  );

  // --------------------------------------------------------------------------
  // engine
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q  <= ST_IDLE;
      act_ch_q <= 5'h00;
      beat_q   <= 11'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          beat_q <= 11'h000;
          if (go) begin
            act_ch_q <= pick_ch;
            state_q  <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          // a cleared enable drops the channel mid-transfer
          if (!en_q[act_ch_q]) begin
            state_q <= ST_IDLE;
          end else if (push) begin
            beat_q <= beat_q + 11'h001;
            if (last) begin
              state_q <= ST_CLOSE;
            end else if (chunk || basic_gone) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_CLOSE: state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // control structures
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < `MCDMA_NUM_STRUCT; i++) begin
        ctrl_mem[i] <= '0;
        rem_mem[i]  <= `MCDMA_REM_RST;
      end
    end else begin
      // separate primary and alternate, count range
      if (CFG_WR_IN) begin
        ctrl_mem[CFG_IDX_IN] <= CFG_CTRL_IN;
        rem_mem[CFG_IDX_IN]  <= {1'b0, CFG_CTRL_IN.count_m1} + 11'h001;
      end
      if (push) begin
        rem_mem[act_idx] <= rem_now - 11'h001;
      end
      if (state_q == ST_CLOSE) begin
        ctrl_mem[act_idx].mode <= mcdma_pkg::MCDMA_HALTED;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (CFG_WR_IN) begin
      src_mem[CFG_IDX_IN] <= CFG_SRC_IN;
      dst_mem[CFG_IDX_IN] <= CFG_DST_IN;
    end
    if (push) begin
      src_mem[act_idx] <= item.src + step_of(act_ctl.src_inc);
      dst_mem[act_idx] <= item.dst + step_of(act_ctl.dst_inc);
    end
  end

  // --------------------------------------------------------------------------
  // channel bits
  // --------------------------------------------------------------------------
  wire  [31:0] ch_bit    = 32'h0000_0001 << act_ch_q;
  wire  [31:0] pick_bit  = go ? (32'h0000_0001 << pick_ch) : 32'h0000_0000;
  wire  [31:0] fin_bit   = finish ? ch_bit : 32'h0000_0000;
  wire  [31:0] attr_bit  = ATTR_WR_IN ? (32'h0000_0001 << ATTR_CH_IN) : 32'h0000_0000;
  wire  [31:0] swap_bit  = (state_q == ST_CLOSE && swap) ? ch_bit : 32'h0000_0000;
  // memory sg runs on like auto, peripheral sg waits for requests
  wire         auto_pick = (ctrl_mem[pick_idx].mode == mcdma_pkg::MCDMA_AUTO)
                           || (ctrl_mem[pick_idx].mode == mcdma_pkg::MCDMA_MEM_SG);

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      en_q      <= `MCDMA_EN_RST;
      sw_pend_q <= 32'h0000_0000;
      started_q <= 32'h0000_0000;
      burst_q   <= `MCDMA_ATTR_RST;
      alt_q     <= `MCDMA_ATTR_RST;
      hipri_q   <= `MCDMA_ATTR_RST;
      mask_q    <= `MCDMA_ATTR_RST;
    end else begin
      en_q      <= (en_q & ~EN_CLR_IN & ~fin_bit) | EN_SET_IN;
      // software request, kept only while enabled
      sw_pend_q <= ((sw_pend_q & ~pick_bit) | SW_REQ_IN) & en_q;
      started_q <= ((started_q & ~fin_bit) | ((auto_pick || sw_pend_q[pick_ch])
                   ? pick_bit : 32'h0000_0000)) & en_q;
      burst_q   <= ATTR_SET_IN[`MCDMA_ATTR_BURST] ? burst_q | attr_bit
                   : ATTR_CLR_IN[`MCDMA_ATTR_BURST] ? burst_q & ~attr_bit : burst_q;
      alt_q     <= (ATTR_SET_IN[`MCDMA_ATTR_ALT] ? alt_q | attr_bit
                   : ATTR_CLR_IN[`MCDMA_ATTR_ALT] ? alt_q & ~attr_bit : alt_q) ^ swap_bit;
      hipri_q   <= ATTR_SET_IN[`MCDMA_ATTR_HIPRI] ? hipri_q | attr_bit
                   : ATTR_CLR_IN[`MCDMA_ATTR_HIPRI] ? hipri_q & ~attr_bit : hipri_q;
      mask_q    <= ATTR_SET_IN[`MCDMA_ATTR_REQMASK] ? mask_q | attr_bit
                   : ATTR_CLR_IN[`MCDMA_ATTR_REQMASK] ? mask_q & ~attr_bit : mask_q;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < `MCDMA_NUM_CH; i++) begin
        map_q[i] <= 5'(i);
      end
    end else if (MAP_WR_IN) begin
      map_q[MAP_CH_IN] <= MAP_SEL_IN;
    end
  end

  // --------------------------------------------------------------------------
  // read back and completion
  // --------------------------------------------------------------------------
  wire [31:0] per_bit = 32'h0000_0001 << map_q[act_ch_q];
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ENABLE_OUT      <= `MCDMA_EN_RST;
      ATTR_OUT        <= 4'h0;
      RD_MODE_OUT     <= mcdma_pkg::MCDMA_HALTED;
      RD_REMAIN_OUT   <= `MCDMA_REM_RST;
      DONE_SW_OUT     <= 1'b0;
      PERIPH_DONE_OUT <= 32'h0000_0000;
      BUSY_OUT        <= 1'b0;
    end else begin
      ENABLE_OUT      <= en_q;
      ATTR_OUT        <= {mask_q[RD_CH_IN], hipri_q[RD_CH_IN], alt_q[RD_CH_IN],
                          burst_q[RD_CH_IN]};
      RD_MODE_OUT     <= ctrl_mem[RD_IDX_IN].mode;
      RD_REMAIN_OUT   <= rem_mem[RD_IDX_IN];
      DONE_SW_OUT     <= (state_q == ST_CLOSE) && (act_ch_q == `MCDMA_SW_CH);
      PERIPH_DONE_OUT <= ((state_q == ST_CLOSE) && (act_ch_q != `MCDMA_SW_CH))
                         ? per_bit : 32'h0000_0000;
      BUSY_OUT        <= state_q != ST_IDLE;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_last_push;
    push && last;
  endsequence
  sequence s_close_sw;
    state_q == ST_CLOSE && act_ch_q == `MCDMA_SW_CH;
  endsequence

  property p_move_enabled;
    push |-> en_q[act_ch_q] || started_q[act_ch_q];
  endproperty
  a_move_enabled: assert property (p_move_enabled) else $error("item moved on idle channel");

  property p_auto_clear;
    s_last_push ##1 (!swap && !EN_SET_IN[act_ch_q]) |=> !en_q[$past(act_ch_q)];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("enable not cleared at end");

  property p_pick_enabled;
    go |-> en_q[pick_ch];
  endproperty
  a_pick_enabled: assert property (p_pick_enabled) else $error("disabled channel picked");

  property p_halted;
    s_last_push |=> ##1 ctrl_mem[$past(act_idx, 2)].mode == mcdma_pkg::MCDMA_HALTED;
  endproperty
  a_halted: assert property (p_halted) else $error("mode not halted after end");

  property p_src_word;
    push && act_ctl.src_inc == mcdma_pkg::MCDMA_INC_WORD && !CFG_WR_IN
      |=> src_mem[$past(act_idx)] == $past(item.src) + 32'h0000_0004;
  endproperty
  a_src_word: assert property (p_src_word) else $error("source not stepped by four");

  property p_rearb;
    push && chunk && !last |=> state_q == ST_IDLE;
  endproperty
  a_rearb: assert property (p_rearb) else $error("no rearbitration after chunk");

  property p_rem_falls;
    push && !CFG_WR_IN |=> rem_mem[$past(act_idx)] == $past(rem_now) - 11'h001;
  endproperty
  a_rem_falls: assert property (p_rem_falls) else $error("remaining count did not fall");

  property p_sw_done;
    s_close_sw |=> DONE_SW_OUT && PERIPH_DONE_OUT == 32'h0000_0000;
  endproperty
  a_sw_done: assert property (p_sw_done) else $error("software done line missed");

  property p_hipri;
    go && (|want_hi) |=> hipri_q[act_ch_q] || $past(ATTR_WR_IN);
  endproperty
  a_hipri: assert property (p_hipri) else $error("low priority beat high");

endmodule // mcdma_ctrl

`default_nettype wire

// File: mcdma_sink_model.sv
// bus-side sink that takes item descriptors, with a stall control
`timescale 1ns/10ps
`default_nettype none
module mcdma_sink_model (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  // item stream
  input  wire mcdma_pkg::mcdma_xfer_t xfer_in,
  input  wire logic                   valid_in,
  output logic                        ready_out,
  input  wire logic                   stall_in,
  output var int                      count_out
);
  mcdma_pkg::mcdma_xfer_t got [0:31];
  // stall holds ready low so the fifo fills
  assign ready_out = !stall_in;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_out <= 0;
    end else if (valid_in && ready_out) begin
      got[count_out[4:0]] <= xfer_in;
      count_out <= count_out + 1;
    end
  end
endmodule // mcdma_sink_model
`default_nettype wire

// File: multichannel_dma_channel_control_tb.sv
// self-checking testbench of the channel control engine
`timescale 1ns/10ps
`default_nettype none
module multichannel_dma_channel_control_tb;
  logic CLK_IN, RESETN_IN, attr_wr, cfg_wr, map_wr, valid, ready, busy, done_sw, stall;
  logic [31:0] en_set, en_clr, enable, sw_req, sreq, breq, p_done, cfg_src, cfg_dst;
  logic [4:0]  attr_ch, rd_ch, map_ch, map_sel;
  logic [3:0]  attr_set, attr_clr, attr_o;
  logic [5:0]  cfg_idx, rd_idx;
  logic [10:0] rd_rem;
  mcdma_pkg::mcdma_ctrl_t cfg_ctrl;
  mcdma_pkg::mcdma_mode_t rd_mode;
  mcdma_pkg::mcdma_xfer_t xfer;
  int num_errors = 0, compares = 0, got_n, b, done_sw_n = 0, done_p9_n = 0;

  mcdma_ctrl u_mcdma_ctrl (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .EN_SET_IN(en_set),
    .EN_CLR_IN(en_clr), .ENABLE_OUT(enable), .ATTR_WR_IN(attr_wr), .ATTR_CH_IN(attr_ch),
    .ATTR_SET_IN(attr_set), .ATTR_CLR_IN(attr_clr), .RD_CH_IN(rd_ch), .ATTR_OUT(attr_o),
    .CFG_WR_IN(cfg_wr), .CFG_IDX_IN(cfg_idx), .CFG_CTRL_IN(cfg_ctrl), .CFG_SRC_IN(cfg_src),
    .CFG_DST_IN(cfg_dst), .RD_IDX_IN(rd_idx), .RD_MODE_OUT(rd_mode), .RD_REMAIN_OUT(rd_rem),
    .MAP_WR_IN(map_wr), .MAP_CH_IN(map_ch), .MAP_SEL_IN(map_sel), .SW_REQ_IN(sw_req),
    .PERIPH_SREQ_IN(sreq), .PERIPH_BREQ_IN(breq), .DONE_SW_OUT(done_sw),
    .PERIPH_DONE_OUT(p_done), .BUS_XFER_OUT(xfer), .BUS_VALID_OUT(valid),
    .BUS_READY_IN(ready), .BUSY_OUT(busy));
  mcdma_sink_model u_mcdma_sink_model (.clk_in(CLK_IN), .resetn_in(RESETN_IN), .xfer_in(xfer),
    .valid_in(valid), .ready_out(ready), .stall_in(stall), .count_out(got_n));

  initial begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end
  always @(posedge CLK_IN) begin
    if (done_sw === 1'b1) done_sw_n++;
    if (p_done[9] === 1'b1) done_p9_n++;
  end
  initial begin
    repeat (6000) @(posedge CLK_IN);
    num_errors++;
    results();
  end

  task automatic results();
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [70:0] seen, input logic [70:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic mcdma_pkg::mcdma_ctrl_t mk(input mcdma_pkg::mcdma_size_t sz,
      input mcdma_pkg::mcdma_inc_t si, di, input logic [3:0] ae,
      input mcdma_pkg::mcdma_mode_t md, input logic [9:0] cm1);
    mk = '{sz, si, di, ae, 1'b0, md, cm1};
  endfunction
  task automatic cfg(input logic [5:0] i, input mcdma_pkg::mcdma_ctrl_t c, input logic [31:0] s, d);
    @(posedge CLK_IN);
    cfg_wr <= 1'b1;
    cfg_idx <= i;
    cfg_ctrl <= c;
    cfg_src <= s;
    cfg_dst <= d;
    @(posedge CLK_IN);
    cfg_wr <= 1'b0;
  endtask
  task automatic pulse(input bit is_sw, input logic [31:0] m);
    @(posedge CLK_IN);
    if (is_sw) sw_req <= m;
    else en_set <= m;
    @(posedge CLK_IN);
    sw_req <= '0;
    en_set <= '0;
  endtask
  task automatic attr(input logic [4:0] ch, input logic [3:0] s, c);
    @(posedge CLK_IN);
    attr_wr <= 1'b1;
    attr_ch <= ch;
    attr_set <= s;
    attr_clr <= c;
    @(posedge CLK_IN);
    attr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i);
    @(posedge CLK_IN);
    rd_idx <= i;
    rd_ch <= i[4:0];
    repeat (2) @(posedge CLK_IN);
    #1;
  endtask
  task automatic wait_off(input logic [31:0] m);
    for (int n = 0; n < 300 && (enable & m) !== '0; n++) @(posedge CLK_IN);
    chk("enable cleared", enable & m, '0);
    repeat (3) @(posedge CLK_IN);
  endtask

  initial begin
    {RESETN_IN, attr_wr, cfg_wr, map_wr, stall, en_set, en_clr, sw_req, sreq, breq} = '0;
    {attr_ch, rd_ch, map_ch, map_sel, attr_set, attr_clr, cfg_idx, rd_idx} = '0;
    {cfg_ctrl, cfg_src, cfg_dst} = '0;
    repeat (5) @(posedge CLK_IN);
    RESETN_IN <= 1'b1;
    rd(6'h00);
    chk("reset", {enable, attr_o, rd_mode, rd_rem}, '0);
    // request on a channel never enabled
    cfg(6'h03, mk(mcdma_pkg::MCDMA_SIZE_32, mcdma_pkg::MCDMA_INC_WORD,
        mcdma_pkg::MCDMA_INC_WORD, 4'h0, mcdma_pkg::MCDMA_BASIC, 10'h001), 32'h300, 32'h400);
    cfg(6'h23, mk(mcdma_pkg::MCDMA_SIZE_8, mcdma_pkg::MCDMA_INC_BYTE,
        mcdma_pkg::MCDMA_INC_BYTE, 4'h0, mcdma_pkg::MCDMA_AUTO, 10'h000), 32'h0, 32'h0);
    pulse(1, 32'h8);
    repeat (10) @(posedge CLK_IN);
    chk("items", got_n, 0);
    rd(6'h03);
    chk("primary", {rd_mode, rd_rem}, {mcdma_pkg::MCDMA_BASIC, 11'h002});
    rd(6'h23);
    chk("alternate", rd_mode, mcdma_pkg::MCDMA_AUTO);
    // software channel, stalled bus fills the fifo
    cfg(6'h1e, mk(mcdma_pkg::MCDMA_SIZE_16, mcdma_pkg::MCDMA_INC_HALF,
        mcdma_pkg::MCDMA_INC_WORD, 4'h1, mcdma_pkg::MCDMA_AUTO, 10'h005), 32'h1000, 32'h2000);
    stall <= 1'b1;
    pulse(0, 32'h4000_0000);
    pulse(1, 32'h4000_0000);
    repeat (20) @(posedge CLK_IN);
    chk("stalled", {valid, busy, got_n[7:0]}, {2'b11, 8'h00});
    stall <= 1'b0;
    wait_off(32'h4000_0000);
    for (int i = 0; i < 6; i++) begin
      chk("item", u_mcdma_sink_model.got[i],
          {32'h1000 + 2 * i, 32'h2000 + 4 * i, mcdma_pkg::MCDMA_SIZE_16, 5'h1e});
    end
    chk("sw done", done_sw_n, 1);
    rd(6'h1e);
    chk("closed", {rd_mode, rd_rem}, {mcdma_pkg::MCDMA_HALTED, 11'h000});
    // channel 4 on peripheral 9: burst-only, then masked
    @(posedge CLK_IN);
    map_wr <= 1'b1;
    map_ch <= 5'h04;
    map_sel <= 5'h09;
    @(posedge CLK_IN);
    map_wr <= 1'b0;
    cfg(6'h04, mk(mcdma_pkg::MCDMA_SIZE_8, mcdma_pkg::MCDMA_INC_BYTE,
        mcdma_pkg::MCDMA_INC_FIXED, 4'h0, mcdma_pkg::MCDMA_BASIC, 10'h001), 32'h50, 32'h60);
    attr(5'h04, 4'h1, 4'h0);
    pulse(0, 32'h10);
    b = got_n;
    sreq <= 32'h200;
    repeat (10) @(posedge CLK_IN);
    chk("single", got_n, b);
    attr(5'h04, 4'h8, 4'h0);
    rd(6'h04);
    chk("attr", attr_o, 4'h9);
    breq <= 32'h200;
    repeat (10) @(posedge CLK_IN);
    chk("masked", got_n, b);
    attr(5'h04, 4'h0, 4'h8);
    wait_off(32'h10);
    breq <= '0;
    sreq <= '0;
    chk("p item", u_mcdma_sink_model.got[b], {32'h50, 32'h60, 2'b00, 5'h04});
    chk("p item", u_mcdma_sink_model.got[b + 1], {32'h51, 32'h60, 2'b00, 5'h04});
    chk("p done", done_p9_n, 1);
    // high priority channel 6 beats channel 3
    cfg(6'h06, mk(mcdma_pkg::MCDMA_SIZE_32, mcdma_pkg::MCDMA_INC_WORD,
        mcdma_pkg::MCDMA_INC_WORD, 4'h0, mcdma_pkg::MCDMA_AUTO, 10'h000), 32'h700, 32'h800);
    attr(5'h06, 4'h4, 4'h0);
    b = got_n;
    pulse(0, 32'h48);
    pulse(1, 32'h48);
    wait_off(32'h48);
    chk("first", u_mcdma_sink_model.got[b], {32'h700, 32'h800, 2'b10, 5'h06});
    chk("next", u_mcdma_sink_model.got[b + 1], {32'h300, 32'h400, 2'b10, 5'h03});
    chk("next", u_mcdma_sink_model.got[b + 2], {32'h304, 32'h404, 2'b10, 5'h03});
    // alternate attribute makes the alternate structure of channel 3 active
    attr(5'h03, 4'h2, 4'h0);
    b = got_n;
    pulse(0, 32'h8);
    pulse(1, 32'h8);
    wait_off(32'h8);
    chk("alt item", u_mcdma_sink_model.got[b], {32'h0, 32'h0, 2'b00, 5'h03});
    // channel 6 double buffer: primary, then alternate, enable kept between
    cfg(6'h06, mk(mcdma_pkg::MCDMA_SIZE_32, mcdma_pkg::MCDMA_INC_WORD,
        mcdma_pkg::MCDMA_INC_WORD, 4'h0, mcdma_pkg::MCDMA_DOUBLE_BUFFER, 10'h000),
        32'h900, 32'ha00);
    cfg(6'h26, mk(mcdma_pkg::MCDMA_SIZE_32, mcdma_pkg::MCDMA_INC_WORD,
        mcdma_pkg::MCDMA_INC_WORD, 4'h0, mcdma_pkg::MCDMA_AUTO, 10'h000), 32'hb00, 32'hc00);
    rd(6'h06);
    chk("db mode", rd_mode, mcdma_pkg::MCDMA_DOUBLE_BUFFER);
    b = got_n;
    pulse(0, 32'h40);
    pulse(1, 32'h40);
    wait_off(32'h40);
    chk("db first", u_mcdma_sink_model.got[b], {32'h900, 32'ha00, 2'b10, 5'h06});
    chk("db second", u_mcdma_sink_model.got[b + 1], {32'hb00, 32'hc00, 2'b10, 5'h06});
    rd(6'h06);
    chk("db end", {rd_mode, attr_o}, {mcdma_pkg::MCDMA_HALTED, 4'h6});
    results();
  end
endmodule // multichannel_dma_channel_control_tb
`default_nettype wire
